// ===== verilog/sei_params.svh
// constants of the serial eeprom instruction engine
`ifndef SEI_PARAMS_SVH
`define SEI_PARAMS_SVH

`define SEI_ADDR_W          15
`define SEI_GROUP_CNT       8192
`define SEI_PAGE_LSB        6
`define SEI_BYTE_ACK_BIT    4'h8
`define SEI_BYTE_DONE_BIT   4'h9
// device type code; value is arbitrary
`define SEI_TYPE_ID         4'h6
`define SEI_ERASED_WORD     32'hFFFFFFFF
`define SEI_CLK_PERIOD_NS   5
`define SEI_PROG_TIME_NS    2000
`define SEI_PROG_CYCLES     (`SEI_PROG_TIME_NS / `SEI_CLK_PERIOD_NS)

`endif

// ===== verilog/sei_pkg.sv
// types of the serial eeprom instruction engine
package sei_pkg;

   typedef struct packed
   {
      logic scl;
      logic sda;
   } sei_bus_t;

   typedef enum logic [2:0]
   {
      S_IDLE,
      S_DEVSEL,
      S_ADDR_HI,
      S_ADDR_LO,
      S_WDATA,
      S_RDATA,
      S_PROG,
      S_WAIT
   } sei_state_t;

endpackage

// ===== verilog/sei_engine.sv
// serial eeprom instruction engine: bus slave, page buffer, ecc array, write timer
`timescale 1ns/100ps

`include "sei_params.svh"

module sei_engine
#(
   parameter int unsigned PROG_CYCLES = `SEI_PROG_CYCLES
)
(
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   input  wire logic              i_link_clk,
   input  wire sei_pkg::sei_bus_t i_bus,
   input  wire logic              i_write_protect_input,
   input  wire logic              i_chip_select_bit2_pin,
   input  wire logic              i_chip_select_bit1_pin,
   input  wire logic              i_chip_select_bit0_pin,
   output logic                   o_sda_o,
   output logic                   o_sda_oe,
   output logic                   o_busy
);
   import sei_pkg::*;

   // ------------------------------------------------------------
   // ecc functions
   // ------------------------------------------------------------
   // hamming code over 38 positions, check bits at powers of two
   function automatic logic [5:0] ecc_gen(input logic [31:0] d);
      logic [5:0] s;
      int         k;
      s = 6'h00;
      k = 0;
      for (int p = 1; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (d[k])
               s = s ^ 6'(p);
            k++;
         end
      end
      return s;
   endfunction

   function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] c);
      logic [5:0]  syn;
      logic [31:0] r;
      int          k;
      syn = ecc_gen(d) ^ c;
      r   = d;
      k   = 0;
      for (int p = 1; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (syn == 6'(p))
               r[k] = ~r[k];
            k++;
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // delivered state: every group erased with matching check bits
   localparam logic [5:0] ERASED_CHK = ecc_gen(`SEI_ERASED_WORD);

   logic [31:0] mem_q [`SEI_GROUP_CNT] = '{default: `SEI_ERASED_WORD};
   logic [5:0]  chk_q [`SEI_GROUP_CNT] = '{default: ERASED_CHK};
   logic [7:0]  buf_q [64];

   function automatic logic [7:0] rd_byte(input logic [14:0] a);
      logic [31:0] w;
      w = ecc_fix(mem_q[a[14:2]], chk_q[a[14:2]]);
      return w[{a[1:0], 3'b000} +: 8];
   endfunction

   // ------------------------------------------------------------
   // link domain synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_s;
   sei_bus_t   bus_s1;
   sei_bus_t   bus_s2;
   sei_bus_t   bus_s3;
   logic [1:0] wp_s;
   logic [2:0] cs_s1;
   logic [2:0] cs_s2;
   logic [1:0] ack_tgl_s;
   logic       link_rst;
   logic       ack_tgl_q;

   always_ff @(posedge i_link_clk)
   begin
      rst_s     <= {rst_s[0], i_reset};
      bus_s1    <= i_bus;
      bus_s2    <= bus_s1;
      bus_s3    <= bus_s2;
      wp_s      <= {wp_s[0], i_write_protect_input};
      cs_s1     <= {i_chip_select_bit2_pin, i_chip_select_bit1_pin, i_chip_select_bit0_pin};
      cs_s2     <= cs_s1;
      ack_tgl_s <= {ack_tgl_s[0], ack_tgl_q};
   end

   assign link_rst = rst_s[1];

   logic start_e;
   logic stop_e;
   logic rise_e;
   logic fall_e;

   assign start_e = bus_s2.scl & bus_s3.scl & bus_s3.sda & ~bus_s2.sda;
   assign stop_e  = bus_s2.scl & bus_s3.scl & ~bus_s3.sda & bus_s2.sda;
   assign rise_e  = bus_s2.scl & ~bus_s3.scl;
   assign fall_e  = ~bus_s2.scl & bus_s3.scl;

   // ------------------------------------------------------------
   // protocol state
   // ------------------------------------------------------------
   sei_state_t  state_q;
   logic [3:0]  cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  out_q;
   logic [14:0] addr_q;
   logic        sda_oe_q;
   logic        ack_q;
   logic        mack_q;
   logic        stop_ok_q;
   logic        busy_q;
   logic [3:0]  grp_q;
   logic [63:0] vld_q;
   logic        req_tgl_q;
   logic        ack_d;
   logic        sel_match;
   logic        rx_state;
   logic        ack_dec;
   logic        byte_end;
   logic [14:0] addr_nx;

   assign sel_match = (shift_q[7:4] == `SEI_TYPE_ID) && (shift_q[3:1] == cs_s2);
   assign rx_state  = (state_q == S_DEVSEL) || (state_q == S_ADDR_HI) ||
                      (state_q == S_ADDR_LO) || (state_q == S_WDATA);
   assign ack_dec   = fall_e && (cnt_q == `SEI_BYTE_ACK_BIT) && !busy_q;
   assign byte_end  = fall_e && (cnt_q == `SEI_BYTE_DONE_BIT) && !busy_q;
   assign addr_nx   = addr_q + 15'h0001;

   logic [7:0]  rd_cur;
   logic [7:0]  rd_nxt;

   assign rd_cur    = rd_byte(addr_q);
   assign rd_nxt    = rd_byte(addr_nx);

   always_comb
   begin
      unique case (state_q)
         S_DEVSEL:  ack_d = sel_match;
         S_ADDR_HI: ack_d = 1'b1;
         S_ADDR_LO: ack_d = 1'b1;
         S_WDATA:   ack_d = !wp_s[1];
         default:    ack_d = 1'b0;
      endcase
   end

   always_ff @(posedge i_link_clk)
   begin
      if (link_rst)
      begin
         state_q   <= S_IDLE;
         cnt_q     <= 4'h0;
         shift_q   <= 8'h00;
         out_q     <= 8'h00;
         addr_q    <= 15'h0000;
         sda_oe_q  <= 1'b0;
         ack_q     <= 1'b0;
         mack_q    <= 1'b1;
         stop_ok_q <= 1'b0;
         busy_q    <= 1'b0;
         grp_q     <= 4'h0;
         vld_q     <= 64'h0;
         req_tgl_q <= 1'b0;
      end
      else if (state_q == S_PROG)
      begin
         grp_q <= grp_q + 4'h1;
         if (grp_q == 4'hF)
         begin
            state_q   <= S_WAIT;
            req_tgl_q <= ~req_tgl_q;
         end
      end
      else if (state_q == S_WAIT)
      begin
         // bus stays ignored until the core timer hands back
         if (ack_tgl_s[1] == req_tgl_q)
         begin
            state_q <= S_IDLE;
            busy_q  <= 1'b0;
            vld_q   <= 64'h0;
         end
      end
      else if (start_e)
      begin
         // a repeated start drops pending write data
         state_q   <= S_DEVSEL;
         cnt_q     <= 4'h0;
         sda_oe_q  <= 1'b0;
         stop_ok_q <= 1'b0;
         vld_q     <= 64'h0;
      end
      else if (stop_e)
      begin
         sda_oe_q <= 1'b0;
         if (stop_ok_q && (vld_q != 64'h0))
         begin
            state_q <= S_PROG;
            grp_q   <= 4'h0;
            busy_q  <= 1'b1;
         end
         else
            state_q <= S_IDLE;
      end
      else if (rise_e && (state_q != S_IDLE))
      begin
         if (cnt_q < `SEI_BYTE_ACK_BIT)
         begin
            cnt_q <= cnt_q + 4'h1;
            if (rx_state)
               shift_q <= {shift_q[6:0], bus_s2.sda};
         end
         else if (cnt_q == `SEI_BYTE_ACK_BIT)
         begin
            cnt_q <= `SEI_BYTE_DONE_BIT;
            if (state_q == S_RDATA)
               mack_q <= bus_s2.sda;
         end
      end
      else if (fall_e && (state_q != S_IDLE))
      begin
         stop_ok_q <= 1'b0;
         if (cnt_q == `SEI_BYTE_ACK_BIT)
         begin
            ack_q    <= ack_d;
            sda_oe_q <= rx_state && ack_d;
         end
         else if (cnt_q == `SEI_BYTE_DONE_BIT)
         begin
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            unique case (state_q)
               S_DEVSEL:
               begin
                  if (!ack_q)
                     state_q <= S_IDLE;
                  else if (shift_q[0])
                  begin
                     state_q  <= S_RDATA;
                     out_q    <= rd_cur;
                     sda_oe_q <= ~rd_cur[7];
                  end
                  else
                     state_q <= S_ADDR_HI;
               end
               S_ADDR_HI:
               begin
                  addr_q[14:8] <= shift_q[6:0];
                  state_q      <= S_ADDR_LO;
               end
               S_ADDR_LO:
               begin
                  addr_q[7:0] <= shift_q;
                  state_q     <= S_WDATA;
               end
               S_WDATA:
               begin
                  stop_ok_q <= 1'b1;
                  if (ack_q)
                  begin
                     addr_q[5:0]        <= addr_q[5:0] + 6'h01;
                     vld_q[addr_q[5:0]] <= 1'b1;
                  end
               end
               S_RDATA:
               begin
                  addr_q <= addr_nx;
                  if (mack_q)
                     state_q <= S_IDLE;
                  else
                  begin
                     out_q    <= rd_nxt;
                     sda_oe_q <= ~rd_nxt[7];
                  end
               end
               default:
                  state_q <= S_IDLE;
            endcase
         end
         else if ((state_q == S_RDATA) && (cnt_q != 4'h0))
         begin
            // open drain: drive low for a zero bit, release for one
            sda_oe_q <= ~out_q[6];
            out_q    <= {out_q[6:0], 1'b0};
         end
      end
   end

   // ------------------------------------------------------------
   // page buffer and group programming
   // ------------------------------------------------------------
   logic [12:0] ga;
   logic [31:0] old_w;
   logic [31:0] new_w;
   logic [3:0]  grp_vld;

   assign ga      = {addr_q[14:6], grp_q};
   assign old_w   = ecc_fix(mem_q[ga], chk_q[ga]);
   assign grp_vld = vld_q[{grp_q, 2'b00} +: 4];

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_merge
         assign new_w[8*i +: 8] = grp_vld[i] ? buf_q[{grp_q, 2'(i)}] : old_w[8*i +: 8];
      end
   endgenerate

   always_ff @(posedge i_link_clk)
   begin
      if (byte_end && (state_q == S_WDATA) && ack_q)
         buf_q[addr_q[5:0]] <= shift_q;
   end

   // whole group rewritten with fresh check bits, one group per cycle
   always_ff @(posedge i_link_clk)
   begin
      if ((state_q == S_PROG) && (grp_vld != 4'h0))
      begin
         mem_q[ga] <= new_w;
         chk_q[ga] <= ecc_gen(new_w);
      end
   end

   assign o_sda_o  = 1'b0;
   assign o_sda_oe = sda_oe_q;

   always_ff @(posedge i_link_clk)
   begin
      if (link_rst)
         o_busy <= 1'b0;
      else
         o_busy <= busy_q;
   end

   // ------------------------------------------------------------
   // core domain program timer
   // ------------------------------------------------------------
   logic [1:0]  req_s;
   logic        req_seen_q;
   logic        run_q;
   logic [15:0] tmr_q;

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         req_s      <= 2'b00;
         req_seen_q <= 1'b0;
         run_q      <= 1'b0;
         tmr_q      <= 16'h0000;
         ack_tgl_q  <= 1'b0;
      end
      else
      begin
         req_s <= {req_s[0], req_tgl_q};
         if (!run_q && (req_s[1] != req_seen_q))
         begin
            run_q      <= 1'b1;
            tmr_q      <= 16'h0000;
            req_seen_q <= req_s[1];
         end
         else if (run_q)
         begin
            if (tmr_q == 16'(PROG_CYCLES - 1))
            begin
               run_q     <= 1'b0;
               ack_tgl_q <= ~ack_tgl_q;
            end
            else
               tmr_q <= tmr_q + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   busy_sda_off_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      busy_q |-> !sda_oe_q) else $error("data line driven while programming");

   sel_nack_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (ack_dec && state_q == S_DEVSEL && !sel_match) |=> !sda_oe_q)
      else $error("mismatched select acknowledged");

   wp_nack_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (ack_dec && state_q == S_WDATA && wp_s[1]) |=> !sda_oe_q && !ack_q)
      else $error("protected data byte acknowledged");

   wdata_ack_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (ack_dec && state_q == S_WDATA && !wp_s[1]) |=> sda_oe_q && ack_q)
      else $error("data byte not acknowledged");

   addr_ack_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (ack_dec && (state_q == S_ADDR_HI || state_q == S_ADDR_LO)) |=> sda_oe_q)
      else $error("address byte not acknowledged");

   rd_incr_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (byte_end && state_q == S_RDATA) |=> addr_q == 15'($past(addr_q) + 15'h0001))
      else $error("read counter did not advance by one");

   wr_page_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (byte_end && state_q == S_WDATA && ack_q) |=>
      (addr_q[14:6] == $past(addr_q[14:6])) &&
      (addr_q[5:0] == 6'($past(addr_q[5:0]) + 6'h01)))
      else $error("write counter left page or did not advance");

   stop_launch_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (stop_e && !busy_q && !stop_ok_q) |=> !busy_q)
      else $error("stop outside tenth slot started programming");

   prog_len_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      $rose(busy_q) |-> busy_q[*8]) else $error("programming ended too early");

   rd_nack_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
      (byte_end && state_q == S_RDATA && mack_q) |=> state_q == S_IDLE ##1 !sda_oe_q)
      else $error("read continued after not-acknowledge");

   rand_read_c: cover property (@(posedge i_link_clk) disable iff (link_rst)
      state_q == S_ADDR_LO ##[1:1000] state_q == S_RDATA);
   prog_done_c: cover property (@(posedge i_link_clk) disable iff (link_rst)
      $fell(busy_q));
   wp_refuse_c: cover property (@(posedge i_link_clk) disable iff (link_rst)
      ack_dec && state_q == S_WDATA && wp_s[1]);
   poll_busy_c: cover property (@(posedge i_link_clk) disable iff (link_rst)
      busy_q && start_e);

endmodule

// ===== verif/sei_master_model.sv
// bus master model that clocks the two-wire link of the engine
`timescale 1ns/100ps

module sei_master_model
(
   input  wire logic i_link_clk,
   input  wire logic i_sda_line,
   output logic      o_scl,
   output logic      o_sda
);
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_link_clk);
      #1;
   endtask

   // ------------------------------------------------------------
   // conditions and bit slots
   // ------------------------------------------------------------
   // sda only moves two clocks after scl falls, so no false start or stop
   task automatic start_cond();
      wait_clk(2);
      o_sda = 1'b1;
      wait_clk(8);
      o_scl = 1'b1;
      wait_clk(8);
      o_sda = 1'b0;
      wait_clk(8);
      o_scl = 1'b0;
   endtask

   task automatic stop_cond();
      wait_clk(2);
      o_sda = 1'b0;
      wait_clk(8);
      o_scl = 1'b1;
      wait_clk(8);
      o_sda = 1'b1;
      wait_clk(8);
   endtask

   task automatic bit_slot(input logic b, output logic s);
      wait_clk(2);
      o_sda = b;
      wait_clk(8);
      o_scl = 1'b1;
      s = i_sda_line;
      wait_clk(8);
      o_scl = 1'b0;
   endtask

   // ------------------------------------------------------------
   // byte transfers
   // ------------------------------------------------------------
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(b[i], s);
      bit_slot(1'b1, s);
      ack = ~s;
   endtask

   task automatic get_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(1'b1, b[i]);
      bit_slot(~more, s);
   endtask
endmodule

// ===== verif/sei_engine_tb.sv
// self-checking bench of the serial eeprom instruction engine
`timescale 1ns/100ps
`include "sei_params.svh"

module sei_engine_tb;
   import sei_pkg::*;
   localparam logic [2:0] CS    = 3'h5;
   localparam logic [7:0] SEL_W = {`SEI_TYPE_ID, CS, 1'b0};
   localparam logic [7:0] SEL_R = {`SEI_TYPE_ID, CS, 1'b1};
   logic       i_clk;
   logic       i_reset;
   logic       i_link_clk;
   logic       wp;
   logic [2:0] cs_pins;
   logic       scl;
   logic       m_sda;
   logic       sda_o;
   logic       sda_oe;
   logic       busy;
   logic       line;
   logic       k;
   logic [7:0] b;
   sei_bus_t   bus;
   int         fails;
   int         total_checks;

   assign line = m_sda & (~sda_oe | sda_o);
   assign bus  = '{scl: scl, sda: line};

   sei_engine #(.PROG_CYCLES(1000)) sei_engine_inst
   (
      .i_clk                  (i_clk),
      .i_reset                (i_reset),
      .i_link_clk             (i_link_clk),
      .i_bus                  (bus),
      .i_write_protect_input  (wp),
      .i_chip_select_bit2_pin (cs_pins[2]),
      .i_chip_select_bit1_pin (cs_pins[1]),
      .i_chip_select_bit0_pin (cs_pins[0]),
      .o_sda_o                (sda_o),
      .o_sda_oe               (sda_oe),
      .o_busy                 (busy)
   );

   sei_master_model sei_master_model_inst
   (
      .i_link_clk (i_link_clk),
      .i_sda_line (line),
      .o_scl      (scl),
      .o_sda      (m_sda)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // link clock offset so its edges never line up with the core clock
   initial
   begin
      i_link_clk = 1'b0;
      #1.3;
      forever #7.5 i_link_clk = ~i_link_clk;
   end

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic put(input logic [7:0] v, input logic exp);
      sei_master_model_inst.put_byte(v, k);
      chk({7'h00, k}, {7'h00, exp});
   endtask

   task automatic rd(input logic more, input logic [7:0] exp);
      sei_master_model_inst.get_byte(more, b);
      chk(b, exp);
   endtask

   task automatic hdr(input logic [15:0] a);
      sei_master_model_inst.start_cond();
      put(SEL_W, 1'b1);
      put(a[15:8], 1'b1);
      put(a[7:0], 1'b1);
   endtask

   task automatic rd_at(input logic [15:0] a);
      hdr(a);
      sei_master_model_inst.start_cond();
      put(SEL_R, 1'b1);
   endtask

   task automatic stop();
      sei_master_model_inst.stop_cond();
   endtask

   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 1000; i++)
      begin
         if (busy === lvl)
            return;
         @(posedge i_link_clk);
      end
      fails++;
      $display("Error at %0t: got %h expected %h", $time, busy, lvl);
      finish_test();
   endtask

   task automatic no_prog();
      repeat (40) @(posedge i_link_clk);
      chk({7'h00, busy}, 8'h00);
   endtask

   // data line must stay released while programming
   always @(negedge i_link_clk)
      if (busy === 1'b1 && sda_oe !== 1'b0)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, sda_oe, 1'b0);
      end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_erased();
      rd_at(16'h0010);
      rd(1'b0, 8'hFF);
      stop();
   endtask

   task automatic t_page_poll();
      hdr(16'h817E);
      for (int i = 1; i <= 5; i++)
         put(i[7:0], 1'b1);
      stop();
      wait_busy(1'b1);
      sei_master_model_inst.start_cond();
      put(SEL_R, 1'b0);
      stop();
      k = 1'b0;
      for (int i = 0; i < 20 && !k; i++)
      begin
         sei_master_model_inst.start_cond();
         sei_master_model_inst.put_byte(SEL_R, k);
         if (!k)
            stop();
      end
      chk({7'h00, k}, 8'h01);
      rd(1'b0, 8'hFF);
      stop();
      rd_at(16'h017C);
      rd(1'b1, 8'hFF);
      rd(1'b1, 8'hFF);
      rd(1'b1, 8'h01);
      rd(1'b0, 8'h02);
      // next byte is erased and starts with a one bit, so a device that kept going would also leave the line released here
      repeat (6) @(posedge i_link_clk);
      chk({7'h00, sda_oe}, 8'h00);
      stop();
      rd_at(16'h0140);
      rd(1'b1, 8'h03);
      rd(1'b1, 8'h04);
      rd(1'b0, 8'h05);
      stop();
   endtask

   task automatic t_protect();
      @(posedge i_clk);
      #1 wp = 1'b1;
      hdr(16'h0200);
      put(8'h55, 1'b0);
      stop();
      no_prog();
      rd_at(16'h0200);
      rd(1'b0, 8'hFF);
      stop();
      @(posedge i_clk);
      #1 wp = 1'b0;
   endtask

   task automatic t_refused();
      hdr(16'h0300);
      stop();
      no_prog();
      sei_master_model_inst.start_cond();
      put({`SEI_TYPE_ID, 3'h2, 1'b0}, 1'b0);
      stop();
      sei_master_model_inst.start_cond();
      put({~`SEI_TYPE_ID, CS, 1'b0}, 1'b0);
      stop();
   endtask

   task automatic t_wrap();
      hdr(16'h0000);
      put(8'hA5, 1'b1);
      put(8'h5A, 1'b1);
      put(8'hC3, 1'b1);
      put(8'h3C, 1'b1);
      stop();
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd_at(16'h7FFF);
      rd(1'b1, 8'hFF);
      rd(1'b1, 8'hA5);
      rd(1'b0, 8'h5A);
      stop();
   endtask

   initial
   begin
      fails = 0;
      total_checks = 0;
      i_reset = 1'b1;
      wp = 1'b0;
      cs_pins = CS;
      // held past four link clock edges as the link side requires
      repeat (16) @(posedge i_clk);
      #1 i_reset = 1'b0;
      repeat (10) @(posedge i_link_clk);
      t_erased();
      t_page_poll();
      t_protect();
      t_refused();
      t_wrap();
      finish_test();
   end
endmodule
